//--- core/rcr_pkg.sv
// Package: receiver configuration register map, fields, resets and types
package rcr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W     = 6;
    localparam int DATA_W     = 8;
    localparam int GUARD_W    = 6;
    localparam int LEVEL_W    = 4;
    localparam int COLL_W     = 3;
    localparam int WAIT_OUT_W = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_RECEIVER_SELECT   = 6'h17;
    localparam logic [ADDR_W-1:0] OFS_DECODER_THRESHOLD = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_DEMODULATOR_SETUP = 6'h19;
    localparam logic [ADDR_W-1:0] OFS_RESERVED_A        = 6'h1a;
    localparam logic [ADDR_W-1:0] OFS_RESERVED_B        = 6'h1b;
    localparam logic [ADDR_W-1:0] OFS_TRANSMIT_WAIT     = 6'h1c;

    // ------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_RECEIVER_SELECT   = 8'h84;
    localparam logic [DATA_W-1:0] RST_DECODER_THRESHOLD = 8'h84;
    localparam logic [DATA_W-1:0] RST_DEMODULATOR_SETUP = 8'h4d;
    localparam logic [DATA_W-1:0] RST_TRANSMIT_WAIT     = 8'h62;
    localparam logic [DATA_W-1:0] WR_RECEIVER_SELECT    = 8'hff;
    localparam logic [DATA_W-1:0] WR_DECODER_THRESHOLD  = 8'hf7;
    localparam logic [DATA_W-1:0] WR_DEMODULATOR_SETUP  = 8'hff;
    localparam logic [DATA_W-1:0] WR_TRANSMIT_WAIT      = 8'h03;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SRC_LSB      = 6;
    localparam int GUARD_LSB    = 0;
    localparam int MINLVL_LSB   = 4;
    localparam int COLL_LSB     = 0;
    localparam int COMBINE_LSB  = 6;
    localparam int FIXED_BIT    = 5;
    localparam int EVEN_BIT     = 4;
    localparam int TAU_RCV_LSB  = 2;
    localparam int TAU_SYNC_LSB = 0;
    localparam int WAIT_LSB     = 0;

    // Response wait offset in bits
    localparam logic [WAIT_OUT_W-1:0] RESP_WAIT_OFFSET = 4'h7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_LOW,
        SRC_AUX_MANCH,
        SRC_ANALOG,
        SRC_AUX_NRZ
    } rcr_src_type;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rcr_host_req_type;

    typedef struct packed {
        logic               bit_valid;
        logic [COLL_W-1:0]  weak_rel;
        logic [LEVEL_W-1:0] strength;
    } rcr_rx_meas_type;

endpackage

//--- core/rcr_guard_timer.sv
// Receiver guard delay counter in bit-clocks
module rcr_guard_timer #(
    parameter int CNT_W = 6
) (
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic             clk_en,
    input  wire logic             bit_tick,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] load_val,
    output logic                  busy
);
    import rcr_pkg::*;

    generate
        if (CNT_W < 1) begin : g_bad_width
            $error("rcr_guard_timer: CNT_W must be at least 1");
        end
    endgenerate

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start) begin
            next_count = load_val;
        end else if (bit_tick && count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (clk_en) begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);

    property p_guard_load;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && start && load_val != '0) |=> busy;
    endproperty
    a_guard_load: assert property (p_guard_load)
        else $error("guard delay did not start");

    property p_guard_hold;
        @(posedge mclk) disable iff (!arst_n)
        (busy && !bit_tick && !start) |=> busy;
    endproperty
    a_guard_hold: assert property (p_guard_hold)
        else $error("guard delay ended without a bit-clock");
endmodule

//--- core/rcr_regs.sv
// Receiver configuration registers and the receive-path logic they steer
// What this block does
// - Source field picks decoder input: low, aux Manchester, analog, aux NRZ.
// - After transmit, receiver stays off for guard bit-clocks; input ignored.
// - Receive-only command skips guard delay; every other command applies it.
// - Guard counter also starts when an external RF field switches on.
// - Decoder ignores input weaker than the minimum-level field.
// - Collision flagged when weak half-bit reaches threshold against strong.
// - Combine 00 picks stronger channel; 01 picks and holds it per session.
// - With fixed-channel set, low combine bit picks I (0) or Q (1).
// - Timer tick every 2*divider+1 carrier cycles, or +2 when even set.
// - Receive time-constant 00 freezes the PLL during reception.
// - Response wait equals the wait field plus seven bits.
// - Receiver select register resets to 84h.
// - Demodulator resets to 4Dh, transmit wait to 62h.
module rcr_regs #(
    parameter int DIV_W = 12
) (
    input  wire logic                      mclk,
    input  wire logic                      arst_n,
    input  wire logic                      clk_en,
    input  rcr_pkg::rcr_host_req_type      host_req,
    output logic [rcr_pkg::DATA_W-1:0]     rdata,
    input  wire logic                      aux_input_pin,
    input  wire logic                      rate_above_106,
    input  wire logic                      i_data,
    input  wire logic                      q_data,
    input  wire logic [3:0]                i_strength,
    input  wire logic [3:0]                q_strength,
    input  rcr_pkg::rcr_rx_meas_type       rx_meas,
    input  wire logic                      tx_done,
    input  wire logic                      cmd_receive_only,
    input  wire logic                      field_on,
    input  wire logic                      bit_tick,
    input  wire logic                      rx_active,
    input  wire logic                      carrier_tick,
    input  wire logic [DIV_W-1:0]          timer_divider,
    output logic                           decoder_in,
    output logic                           rx_enable,
    output logic                           collision,
    output logic                           use_q,
    output logic                           timer_tick,
    output logic                           pll_freeze,
    output logic [1:0]                     pll_tc,
    output logic [rcr_pkg::WAIT_OUT_W-1:0] response_wait_bits
);
    import rcr_pkg::*;

    generate
        if (DIV_W < 1 || DIV_W > 24) begin : g_bad_div
            $error("rcr_regs: DIV_W must be 1 to 24");
        end
    endgenerate

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [DATA_W-1:0] receiver_select;
    logic [DATA_W-1:0] decoder_threshold;
    logic [DATA_W-1:0] demodulator_setup;
    logic [DATA_W-1:0] transmit_wait;
    logic [DATA_W-1:0] next_receiver_select;
    logic [DATA_W-1:0] next_decoder_threshold;
    logic [DATA_W-1:0] next_demodulator_setup;
    logic [DATA_W-1:0] next_transmit_wait;
    logic [DATA_W-1:0] next_rdata;

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [DATA_W-1:0] mask
    );
        merge = (old_val & ~mask) | (new_val & mask);
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] ofs);
        hit = host_req.wr && host_req.addr == ofs;
    endfunction

    always_comb begin
        next_receiver_select   = receiver_select;
        next_decoder_threshold = decoder_threshold;
        next_demodulator_setup = demodulator_setup;
        next_transmit_wait     = transmit_wait;
        // Reserved bits masked off
        if (hit(OFS_RECEIVER_SELECT)) begin
            next_receiver_select = merge(receiver_select, host_req.wdata,
                                         WR_RECEIVER_SELECT);
        end
        if (hit(OFS_DECODER_THRESHOLD)) begin
            next_decoder_threshold = merge(decoder_threshold,
                                           host_req.wdata,
                                           WR_DECODER_THRESHOLD);
        end
        if (hit(OFS_DEMODULATOR_SETUP)) begin
            next_demodulator_setup = merge(demodulator_setup,
                                           host_req.wdata,
                                           WR_DEMODULATOR_SETUP);
        end
        if (hit(OFS_TRANSMIT_WAIT)) begin
            next_transmit_wait = merge(transmit_wait, host_req.wdata,
                                       WR_TRANSMIT_WAIT);
        end
    end

    always_comb begin
        next_rdata = '0;
        if (host_req.rd) begin
            unique case (host_req.addr)
                OFS_RECEIVER_SELECT:   next_rdata = receiver_select;
                OFS_DECODER_THRESHOLD: next_rdata = decoder_threshold
                                                    & WR_DECODER_THRESHOLD;
                OFS_DEMODULATOR_SETUP: next_rdata = demodulator_setup;
                OFS_TRANSMIT_WAIT:     next_rdata = transmit_wait
                                                    & WR_TRANSMIT_WAIT;
                default:               next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            receiver_select   <= RST_RECEIVER_SELECT;
            decoder_threshold <= RST_DECODER_THRESHOLD;
            demodulator_setup <= RST_DEMODULATOR_SETUP;
            transmit_wait     <= RST_TRANSMIT_WAIT;
            rdata             <= '0;
        end else if (clk_en) begin
            receiver_select   <= next_receiver_select;
            decoder_threshold <= next_decoder_threshold;
            demodulator_setup <= next_demodulator_setup;
            transmit_wait     <= next_transmit_wait;
            rdata             <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------
    rcr_src_type        source_sel;
    logic [GUARD_W-1:0] guard_bits;
    logic [LEVEL_W-1:0] min_level;
    logic [COLL_W-1:0]  coll_thr;
    logic [1:0]         combine;
    logic               fixed_ch;
    logic               even_pre;
    logic [1:0]         tau_rcv;
    logic [1:0]         tau_sync;
    logic [1:0]         wait_extra;

    assign source_sel = rcr_src_type'(receiver_select[SRC_LSB +: 2]);
    assign guard_bits = receiver_select[GUARD_LSB +: GUARD_W];
    assign min_level  = decoder_threshold[MINLVL_LSB +: LEVEL_W];
    assign coll_thr   = decoder_threshold[COLL_LSB +: COLL_W];
    assign combine    = demodulator_setup[COMBINE_LSB +: 2];
    assign fixed_ch   = demodulator_setup[FIXED_BIT];
    assign even_pre   = demodulator_setup[EVEN_BIT];
    assign tau_rcv    = demodulator_setup[TAU_RCV_LSB +: 2];
    assign tau_sync   = demodulator_setup[TAU_SYNC_LSB +: 2];
    assign wait_extra = transmit_wait[WAIT_LSB +: 2];

    // ------------------------------------------------------------
    // Guard delay
    // ------------------------------------------------------------
    logic guard_start;
    logic guard_busy;

    assign guard_start = (tx_done && !cmd_receive_only)
                         || field_on;

    rcr_guard_timer #(
        .CNT_W (GUARD_W)
    ) u_guard (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .bit_tick (bit_tick),
        .start    (guard_start),
        .load_val (guard_bits),
        .busy     (guard_busy)
    );

    // ------------------------------------------------------------
    // Channel choice, decoder input and collision
    // ------------------------------------------------------------
    logic active_d;
    logic held_q;
    logic next_active_d;
    logic next_held_q;
    logic stronger_q;
    logic next_use_q;
    logic chan_data;
    logic src_bit;
    logic level_ok;
    logic next_decoder_in;
    logic next_collision;
    logic next_rx_enable;

    assign stronger_q = q_strength > i_strength;

    always_comb begin
        next_active_d = rx_active;
        next_held_q   = held_q;
        if (rx_active && !active_d) begin
            next_held_q = stronger_q;
        end
        if (fixed_ch) begin
            next_use_q = combine[0];
        end else if (combine == 2'b01) begin
            next_use_q = (rx_active && active_d) ? held_q
                                                 : stronger_q;
        end else if (combine == 2'b00) begin
            next_use_q = stronger_q;
        end else begin
            next_use_q = use_q;
        end
    end

    assign chan_data = use_q ? q_data : i_data;
    assign level_ok  = rx_meas.strength >= min_level;

    always_comb begin
        unique case (source_sel)
            SRC_LOW:       src_bit = 1'b0;
            SRC_AUX_MANCH: src_bit = aux_input_pin;
            SRC_ANALOG:    src_bit = chan_data;
            SRC_AUX_NRZ:   src_bit = aux_input_pin && rate_above_106;
        endcase
        next_rx_enable  = !guard_busy;
        next_decoder_in = src_bit && !guard_busy && level_ok;
        next_collision  = rx_meas.bit_valid && !guard_busy && level_ok
                          && rx_meas.weak_rel >= coll_thr;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            active_d   <= 1'b0;
            held_q     <= 1'b0;
            use_q      <= 1'b0;
            decoder_in <= 1'b0;
            rx_enable  <= 1'b0;
            collision  <= 1'b0;
        end else if (clk_en) begin
            active_d   <= next_active_d;
            held_q     <= next_held_q;
            use_q      <= next_use_q;
            decoder_in <= next_decoder_in;
            rx_enable  <= next_rx_enable;
            collision  <= next_collision;
        end
    end

    // ------------------------------------------------------------
    // Timer prescaler, PLL and response wait
    // ------------------------------------------------------------
    localparam int PER_W = DIV_W + 2;
    logic [PER_W-1:0]      pre_count;
    logic [PER_W-1:0]      next_pre_count;
    logic [PER_W-1:0]      period_last;
    logic                  next_timer_tick;
    logic                  next_pll_freeze;
    logic [1:0]            next_pll_tc;
    logic [WAIT_OUT_W-1:0] next_wait_bits;

    // Period minus one: 2*div for odd mode, 2*div+1 for even mode
    assign period_last = {1'b0, timer_divider, even_pre};

    always_comb begin
        next_pre_count  = pre_count;
        next_timer_tick = 1'b0;
        if (carrier_tick) begin
            if (pre_count >= period_last) begin
                next_pre_count  = '0;
                next_timer_tick = 1'b1;
            end else begin
                next_pre_count = pre_count + 1'b1;
            end
        end
        next_pll_freeze = rx_active && tau_rcv == 2'b00;
        next_pll_tc     = rx_active ? tau_rcv : tau_sync;
        next_wait_bits  = {2'b00, wait_extra} + RESP_WAIT_OFFSET;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pre_count          <= '0;
            timer_tick         <= 1'b0;
            pll_freeze         <= 1'b0;
            pll_tc             <= 2'b00;
            response_wait_bits <= '0;
        end else if (clk_en) begin
            pre_count          <= next_pre_count;
            timer_tick         <= next_timer_tick;
            pll_freeze         <= next_pll_freeze;
            pll_tc             <= next_pll_tc;
            response_wait_bits <= next_wait_bits;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_src_low;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && source_sel == SRC_LOW) |=> !decoder_in;
    endproperty
    a_src_low: assert property (p_src_low)
        else $error("decoder input not low for source 00");

    property p_guard_block;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && guard_busy) |=> (!decoder_in && !rx_enable);
    endproperty
    a_guard_block: assert property (p_guard_block)
        else $error("receive input passed during guard delay");

    property p_rx_only_skip;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && tx_done && cmd_receive_only && !field_on && !guard_busy)
            |=> !guard_busy;
    endproperty
    a_rx_only_skip: assert property (p_rx_only_skip)
        else $error("receive-only command started guard delay");

    property p_field_start;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && field_on && guard_bits != '0) |=> guard_busy;
    endproperty
    a_field_start: assert property (p_field_start)
        else $error("field on did not start guard delay");

    property p_min_level;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && rx_meas.strength < min_level) |=> !decoder_in;
    endproperty
    a_min_level: assert property (p_min_level)
        else $error("weak input reached decoder");

    property p_collision;
        @(posedge mclk) disable iff (!arst_n)
        clk_en |=> (collision == $past(rx_meas.bit_valid && !guard_busy
                    && level_ok && rx_meas.weak_rel >= coll_thr));
    endproperty
    a_collision: assert property (p_collision)
        else $error("collision flag wrong");

    property p_fixed_chan;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && fixed_ch) |=> (use_q == $past(combine[0]));
    endproperty
    a_fixed_chan: assert property (p_fixed_chan)
        else $error("fixed channel not honoured");

    property p_hold_chan;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && !fixed_ch && combine == 2'b01 && rx_active && active_d
            && $past(clk_en) && $past(rx_active)) |=> $stable(use_q);
    endproperty
    a_hold_chan: assert property (p_hold_chan)
        else $error("held channel changed during communication");

    property p_pll_freeze;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && rx_active && tau_rcv == 2'b00) |=> pll_freeze;
    endproperty
    a_pll_freeze: assert property (p_pll_freeze)
        else $error("PLL not frozen during reception");

    property p_resp_wait;
        @(posedge mclk) disable iff (!arst_n)
        clk_en |=> (response_wait_bits == $past(wait_extra) + 4'h7);
    endproperty
    a_resp_wait: assert property (p_resp_wait)
        else $error("response wait not field plus seven");

    property p_reset_vals;
        @(posedge mclk) disable iff (!arst_n)
        !$past(arst_n) |-> (receiver_select == 8'h84
            && demodulator_setup == 8'h4d && transmit_wait == 8'h62);
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("register reset value wrong");

    property p_rsvd_read;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && host_req.rd && (host_req.addr == OFS_RESERVED_A
            || host_req.addr == OFS_RESERVED_B)) |=> rdata == 8'h00;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved register read nonzero");
endmodule

//--- test/tb.sv
// Self-checking bench for the receiver configuration registers
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rcr_pkg::*;
    logic              mclk, arst_n, cre, aux, rate, idat, qdat, rxa, ctick;
    logic              ronly, pend, dec, rxen, coll, useq, tt, frz;
    logic [3:0]        istr, qstr, rwb;
    logic [2:0]        pls;
    logic [11:0]       div;
    logic [1:0]        tc;
    logic [7:0]        rdata;
    logic [31:0]       rnd;
    rcr_host_req_type  req;
    rcr_rx_meas_type   meas;
    logic [7:0]        exp_q[$];
    int                bad_count, checks;
    logic [5:0]        ofs [4] = '{OFS_RECEIVER_SELECT, OFS_DECODER_THRESHOLD,
                                   OFS_DEMODULATOR_SETUP, OFS_TRANSMIT_WAIT};
    logic [7:0]        msk [4] = '{8'hff, 8'hf7, 8'hff, 8'h03};

    rcr_regs u_dut (.mclk(mclk), .arst_n(arst_n), .clk_en(cre), .host_req(req),
        .rdata(rdata), .aux_input_pin(aux), .rate_above_106(rate),
        .i_data(idat), .q_data(qdat), .i_strength(istr), .q_strength(qstr),
        .rx_meas(meas), .tx_done(pls[0]), .cmd_receive_only(ronly),
        .field_on(pls[1]), .bit_tick(pls[2]), .rx_active(rxa),
        .carrier_tick(ctick), .timer_divider(div), .decoder_in(dec),
        .rx_enable(rxen), .collision(coll), .use_q(useq), .timer_tick(tt),
        .pll_freeze(frz), .pll_tc(tc), .response_wait_bits(rwb));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic cmp(logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Read data stand one cycle after the read strobe
    always @(posedge mclk) begin
        if (pend) cmp(exp_q.pop_front(), rdata);
        pend = arst_n && req.rd;
    end

    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk) req <= '0;
    endtask

    task automatic rd(logic [5:0] a, logic [7:0] e);
        exp_q.push_back(e);
        @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk) req <= '0;
    endtask

    task automatic pulse(int b);
        @(posedge mclk) pls <= 3'(1 << b);
        @(posedge mclk) pls <= '0;
    endtask

    task automatic look();
        repeat (3) @(negedge mclk);
    endtask

    task automatic period(int e);
        int n = 0;
        while (tt !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (tt !== 1'b1 && n < 40);
        cmp(8'(e), 8'(n));
        if (n >= 40) finish_test();
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        arst_n = 1'b0; cre = 1'b1; aux = 1'b0; rate = 1'b0; idat = 1'b0;
        qdat = 1'b0; rxa = 1'b0; ctick = 1'b1; ronly = 1'b0;
        istr = 4'h5; qstr = 4'h3; pls = '0; div = 12'h002; req = '0;
        meas = '{1'b0, 3'h0, 4'hf}; rnd = 32'h72b1;
        bad_count = 0; checks = 0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        rd(OFS_RECEIVER_SELECT, 8'h84);
        rd(OFS_DEMODULATOR_SETUP, 8'h4d);
        rd(OFS_TRANSMIT_WAIT, 8'h02);
        rd(OFS_DECODER_THRESHOLD, 8'h84);
        for (int i = 0; i < 3; i++) begin
            wr(i == 2 ? 6'h3f : OFS_RESERVED_A + 6'(i), 8'hff);
            rd(i == 2 ? 6'h3f : OFS_RESERVED_A + 6'(i), 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wr(ofs[i], rnd[7:0]);
            rd(ofs[i], rnd[7:0] & msk[i]);
        end
        for (int w = 0; w < 4; w++) begin
            wr(OFS_TRANSMIT_WAIT, 8'(w));
            look();
            cmp(8'(w + 7), 8'(rwb));
        end
        wr(OFS_DECODER_THRESHOLD, 8'h84);
        wr(OFS_RECEIVER_SELECT, 8'h43);
        @(posedge mclk) aux <= 1'b1;
        meas <= '{1'b1, 3'h4, 4'h7};
        look();
        cmp(8'h00, {6'h0, coll, dec});
        @(posedge mclk) meas <= '{1'b1, 3'h4, 4'h8};
        look();
        cmp(8'h03, {6'h0, coll, dec});
        @(posedge mclk) meas <= '{1'b1, 3'h3, 4'h8};
        look();
        cmp(8'h00, 8'(coll));
        wr(OFS_RECEIVER_SELECT, 8'hc3);
        look();
        cmp(8'h00, 8'(dec));
        @(posedge mclk) rate <= 1'b1;
        look();
        cmp(8'h01, 8'(dec));
        wr(OFS_RECEIVER_SELECT, 8'h03);
        look();
        cmp(8'h00, 8'(dec));
        wr(OFS_RECEIVER_SELECT, 8'h43);
        @(posedge mclk) ronly <= 1'b1;
        meas <= '{1'b1, 3'h4, 4'h8};
        pulse(0);
        look();
        cmp(8'h07, {5'h0, coll, dec, rxen});
        @(posedge mclk) ronly <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            pulse(k);
            repeat (2) pulse(2);
            look();
            cmp(8'h00, {5'h0, coll, dec, rxen});
            pulse(2);
            look();
            cmp(8'h07, {5'h0, coll, dec, rxen});
        end
        wr(OFS_RECEIVER_SELECT, 8'h83);
        @(posedge mclk) qstr <= 4'h9;
        idat <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(OFS_DEMODULATOR_SETUP, m ? 8'h60 : 8'h20);
            look();
            cmp(m ? 8'h02 : 8'h01, {6'h0, useq, dec});
        end
        wr(OFS_DEMODULATOR_SETUP, 8'h00);
        @(posedge mclk) qstr <= 4'h3;
        look();
        cmp(8'h00, 8'(useq));
        wr(OFS_DEMODULATOR_SETUP, 8'h40);
        @(posedge mclk) qstr <= 4'h9;
        @(posedge mclk) rxa <= 1'b1;
        @(posedge mclk) qstr <= 4'h3;
        look();
        cmp(8'h01, 8'(useq));
        wr(OFS_DEMODULATOR_SETUP, 8'h00);
        look();
        cmp(8'h04, {5'h0, frz, tc});
        wr(OFS_DEMODULATOR_SETUP, 8'h0e);
        look();
        cmp(8'h03, {5'h0, frz, tc});
        @(posedge mclk) rxa <= 1'b0;
        look();
        cmp(8'h02, {5'h0, frz, tc});
        period(5);
        wr(OFS_DEMODULATOR_SETUP, 8'h1e);
        period(6);
        look();
        finish_test();
    end
endmodule
